// >>> bench/fes_top_bench.sv
// self-checking bench for the receive framer event status block
`timescale 1ns/1ns
module fes_top_bench
  import fes_pkg::*;
;
  // stimulus and observed signals
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  fes_event_t  ev      = '0;
  logic        good    = 1'b0;
  logic [3:0]  awaddr  = 4'h0;
  logic [3:0]  araddr  = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, out_of_frame_flag;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          n_checks   = 0;

  // 25 mhz clock
  always #20 clk_i = ~clk_i;

  fes_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .event_i(ev), .fas_good_i(good),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
    .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
    .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
    .s_rvalid_o(rvalid), .s_rready_i(rready), .irq_o(irq), .oof_o(out_of_frame_flag)
  );

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single register write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s = 4'hf);
    logic aw_open;
    logic w_open;
    logic done;
    aw_open = 1'b1;
    w_open  = 1'b1;
    done    = 1'b0;
    awaddr  <= a[3:0];
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // wait for the answer; only the watchdog ends a hung wait
    while (!done) begin
      @(posedge clk_i);
      if (aw_open && awready) begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready) begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, RESP_OKAY});
        done = 1'b1;
      end
    end
    // one idle edge keeps the release apart from the next request
    @(posedge clk_i);
  endtask

  // single register read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    logic ar_open;
    logic done;
    ar_open = 1'b1;
    done    = 1'b0;
    d       = 32'h0;
    araddr  <= a[3:0];
    arvalid <= 1'b1;
    rready  <= 1'b1;
    // wait for the answer; only the watchdog ends a hung wait
    while (!done) begin
      @(posedge clk_i);
      if (ar_open && arready) begin
        ar_open = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        check({30'h0, rresp}, {30'h0, RESP_OKAY});
        done = 1'b1;
      end
    end
    // one idle edge keeps the release apart from the next request
    @(posedge clk_i);
  endtask

  // one-cycle framer event, then let it settle
  task automatic pulse(input logic [3:0] e, input logic g);
    ev   <= fes_event_t'(e);
    good <= g;
    @(posedge clk_i);
    ev   <= '0;
    good <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // reset values and read-only behaviour of the status word
  task automatic t_reset_values();
    logic [31:0] d;
    axi_read(ADDR_STATUS, d);
    check(d, {27'h0, STATUS_RST});
    axi_read(ADDR_ENABLE, d);
    check(d, {27'h0, ENABLE_RST});
    axi_read(ADDR_FRAMING, d);
    check(d, {29'h0, THR_RST});
    axi_write(ADDR_ENABLE, 32'h1f, 4'he);
    axi_read(ADDR_ENABLE, d);
    check(d, {27'h0, ENABLE_RST});
    axi_write(ADDR_STATUS, 32'h1f);
    axi_read(ADDR_STATUS, d);
    check(d, 32'h0);
    check({31'h0, out_of_frame_flag}, 32'h0);
  endtask

  // each event alone: latch, gate by its own enable, clear on read
  task automatic t_events();
    logic [31:0] d;
    int          b;
    for (int i = 0; i < 4; i++) begin
      b = (i == 3) ? BIT_SHIFT : i;
      axi_write(ADDR_ENABLE, 32'h1f ^ (32'h1 << b));
      pulse(4'h1 << i, 1'b0);
      check({31'h0, irq}, 32'h0);
      axi_write(ADDR_ENABLE, 32'h1 << b);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq}, 32'h1);
      axi_read(ADDR_STATUS, d);
      check(d, 32'h1 << b);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq}, 32'h0);
      axi_read(ADDR_STATUS, d);
      check(d, 32'h0);
    end
  endtask

  // out-of-frame declared at threshold two, then cleared by a good pattern
  task automatic t_oof();
    logic [31:0] d;
    axi_write(ADDR_FRAMING, 32'h2);
    pulse(4'h0, 1'b1);
    axi_read(ADDR_STATUS, d);
    pulse(4'h1, 1'b0);
    check({31'h0, out_of_frame_flag}, 32'h0);
    axi_read(ADDR_STATUS, d);
    check(d, 32'h1);
    pulse(4'h1, 1'b0);
    check({31'h0, out_of_frame_flag}, 32'h1);
    axi_read(ADDR_STATE, d);
    check(d, 32'h1);
    axi_read(ADDR_STATUS, d);
    check(d, 32'h9);
    pulse(4'h0, 1'b1);
    check({31'h0, out_of_frame_flag}, 32'h0);
    axi_read(ADDR_STATUS, d);
    check(d, 32'h8);
  endtask

  // event lands on the very edge that takes the status read
  task automatic t_read_race();
    logic [31:0] d;
    ev <= fes_event_t'(4'h2);
    fork
      axi_read(ADDR_STATUS, d);
      begin
        @(posedge clk_i);
        ev <= '0;
      end
    join
    check(d, 32'h0);
    axi_read(ADDR_STATUS, d);
    check(d, 32'h2);
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values();
    t_events();
    t_oof();
    t_read_race();
    finish_test();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule // fes_top_bench

// >>> hdl/fes_pkg.sv
// package for the receive framer event status block
package fes_pkg;
  // register byte addresses (AXI4-Lite, aligned words)
  localparam logic [7:0] ADDR_STATUS = 8'h00; // framer_event_status
  localparam logic [7:0] ADDR_ENABLE = 8'h04; // interrupt enable
  localparam logic [7:0] ADDR_FRAMING = 8'h08; // framing control
  localparam logic [7:0] ADDR_STATE = 8'h0c; // framer live state

  // status and enable bit positions
  localparam int BIT_FRAMING_ERR = 0;
  localparam int BIT_CRC4_ERR = 1;
  localparam int BIT_MIMIC = 2;
  localparam int BIT_OOF = 3;
  localparam int BIT_SHIFT = 4;
  localparam int NUM_EVENTS = 5;

  // alignment_loss_threshold field in framing control
  localparam int THR_LSB = 0;
  localparam int THR_W = 3;

  // reset values
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [4:0] ENABLE_RST = 5'h00;
  localparam logic [2:0] THR_RST = 3'h3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // events reported by the receive framer datapath
  typedef struct packed {
    logic shift; // alignment moved
    logic mimic; // frame mimic seen
    logic crc4_err; // sub-multiframe crc mismatch
    logic fas_err; // errored alignment pattern in frame
  } fes_event_t;

  // write response channel state
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } fes_wr_t;
endpackage : fes_pkg

// >>> hdl/fes_top.sv
// receive framer event status register with enables and AXI4-Lite slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
// Notes on behaviour
// - flags show events since last status read; reading clears all flags
// - bit 4 latches when alignment shifts to another bit position
// - bit 3 latches on out-of-frame declare and on its clear
// - out-of-frame declared after threshold consecutive errored alignment patterns
// - bit 2 latches on frame mimic detection
// - bit 1 latches on crc-4 sub-multiframe mismatch
// - bit 0 latches on any errored alignment bit
// - framing error flag alone does not mean loss of sync
// - interrupt raised only for latched events whose enable is set
// - enable bits match status bit positions; 1 enables, 0 disables
module fes_top
  import fes_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire fes_event_t  event_i,   // one-cycle event pulses, clk_i domain
  input  wire logic        fas_good_i, // valid alignment pattern found
  input  wire logic [3:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [3:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  output logic             irq_o,
  output logic             oof_o
);

  logic [4:0]       status_q;
  logic [4:0]       enable_q;
  logic [THR_W-1:0] thr_q;
  logic [THR_W-1:0] err_cnt_q;
  logic             oof_q;
  logic             oof_chg;
  logic             status_rd;
  logic [4:0]       set_vec;
  logic             aw_have_q;
  logic             w_have_q;
  logic [3:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  fes_wr_t          wr_st_q;
  logic             wr_fire;

  // widen a 4-bit bus address to the map width
  function automatic logic [7:0] fes_addr(input logic [3:0] a);
    return {4'h0, a[3:2], 2'b00};
  endfunction

  // out-of-frame tracker: count consecutive errored patterns
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_cnt_q <= '0;
      oof_q     <= 1'b0;
    end else if (!oof_q) begin
      if (event_i.fas_err) begin
        if (err_cnt_q + 3'h1 >= thr_q) begin
          oof_q     <= 1'b1;
          err_cnt_q <= '0;
        end else begin
          err_cnt_q <= err_cnt_q + 3'h1;
        end
      end else if (fas_good_i) begin
        err_cnt_q <= '0;
      end
    end else if (fas_good_i) begin
      oof_q <= 1'b0;
    end
  end

  assign oof_chg = (!oof_q && event_i.fas_err && (err_cnt_q + 3'h1 >= thr_q))
                   || (oof_q && fas_good_i);

  // event bit vector at status positions
  always_comb begin
    set_vec = '0;
    set_vec[BIT_SHIFT]       = event_i.shift;
    set_vec[BIT_OOF]         = oof_chg;
    set_vec[BIT_MIMIC]       = event_i.mimic;
    set_vec[BIT_CRC4_ERR]    = event_i.crc4_err;
    set_vec[BIT_FRAMING_ERR] = event_i.fas_err;
  end

  assign status_rd = s_arvalid_i && s_arready_o
                     && (fes_addr(s_araddr_i) == ADDR_STATUS);

  // sticky flags; set wins over the clear of a read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= STATUS_RST;
    end else if (status_rd) begin
      status_q <= set_vec;
    end else begin
      status_q <= status_q | set_vec;
    end
  end

  // interrupt and state outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      oof_o <= 1'b0;
    end else begin
      irq_o <= |(status_q & enable_q);
      oof_o <= oof_q;
    end
  end

  // write address and data capture, either order
  assign wr_fire = aw_have_q && w_have_q && (wr_st_q == WR_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_have_q   <= 1'b0;
      s_awready_o <= 1'b1;
      awaddr_q    <= '0;
    end else if (s_awvalid_i && s_awready_o) begin
      aw_have_q   <= 1'b1;
      s_awready_o <= 1'b0;
      awaddr_q    <= s_awaddr_i;
    end else if (wr_fire) begin
      aw_have_q   <= 1'b0;
    end else if (wr_st_q == WR_RESP && s_bready_i) begin
      s_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_have_q   <= 1'b0;
      s_wready_o <= 1'b1;
      wdata_q    <= '0;
      wstrb_q    <= '0;
    end else if (s_wvalid_i && s_wready_o) begin
      w_have_q   <= 1'b1;
      s_wready_o <= 1'b0;
      wdata_q    <= s_wdata_i;
      wstrb_q    <= s_wstrb_i;
    end else if (wr_fire) begin
      w_have_q   <= 1'b0;
    end else if (wr_st_q == WR_RESP && s_bready_i) begin
      s_wready_o <= 1'b1;
    end
  end

  // write response and register update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_st_q    <= WR_IDLE;
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= RESP_OKAY;
      enable_q   <= ENABLE_RST;
      thr_q      <= THR_RST;
    end else begin
      case (wr_st_q)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_st_q    <= WR_RESP;
            s_bvalid_o <= 1'b1;
            s_bresp_o  <= RESP_OKAY;
            case (fes_addr(awaddr_q))
              ADDR_ENABLE: begin
                if (wstrb_q[0]) enable_q <= wdata_q[4:0];
              end
              ADDR_FRAMING: begin
                if (wstrb_q[0]) thr_q <= wdata_q[THR_LSB +: THR_W];
              end
              ADDR_STATUS: ; // read-only, write ignored
              ADDR_STATE: ;
              default: s_bresp_o <= RESP_SLVERR;
            endcase
          end
        end
        WR_RESP: begin
          if (s_bready_i) begin
            wr_st_q    <= WR_IDLE;
            s_bvalid_o <= 1'b0;
          end
        end
        default: wr_st_q <= WR_IDLE;
      endcase
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_arready_o <= 1'b1;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= '0;
      s_rresp_o   <= RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b1;
      s_rresp_o   <= RESP_OKAY;
      case (fes_addr(s_araddr_i))
        ADDR_STATUS:  s_rdata_o <= {27'h0, status_q};
        ADDR_ENABLE:  s_rdata_o <= {27'h0, enable_q};
        ADDR_FRAMING: s_rdata_o <= {29'h0, thr_q};
        ADDR_STATE:   s_rdata_o <= {28'h0, err_cnt_q, oof_q};
        default: begin
          s_rdata_o <= '0;
          s_rresp_o <= RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o  <= 1'b0;
      s_arready_o <= 1'b1;
    end
  end

  // steps used by the checks below
  sequence s_read_clear;
    status_rd ##1 1'b1;
  endsequence

  sequence s_oof_declare;
    !oof_q && event_i.fas_err && (err_cnt_q + 3'h1 >= thr_q);
  endsequence

  sequence s_oof_release;
    oof_q && fas_good_i;
  endsequence

  sequence s_irq_armed;
    (status_q & enable_q) != 5'h0;
  endsequence

  // checks on the sticky flags and their clear by a read
  chk_read_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_read_clear |-> (status_q == $past(set_vec)))
    else $error("status not cleared by read");
  chk_event_kept: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (status_rd && set_vec != 5'h0) |=>
    ((status_q & $past(set_vec)) == $past(set_vec)))
    else $error("event lost during read");
  chk_flag_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !status_rd |=> ((status_q & $past(status_q)) == $past(status_q)))
    else $error("flag dropped without a read");
  chk_shift_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    event_i.shift |=> status_q[BIT_SHIFT])
    else $error("shift flag not set");
  chk_mimic_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    event_i.mimic |=> status_q[BIT_MIMIC])
    else $error("mimic flag not set");
  chk_crc_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    event_i.crc4_err |=> status_q[BIT_CRC4_ERR])
    else $error("crc flag not set");
  chk_fas_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    event_i.fas_err |=> status_q[BIT_FRAMING_ERR])
    else $error("framing error flag not set");

  // checks on the out-of-frame tracker
  chk_oof_both: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($changed(oof_q)) |-> status_q[BIT_OOF])
    else $error("oof change not flagged");
  chk_oof_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_oof_declare |=> (oof_q && status_q[BIT_OOF]))
    else $error("oof declare not taken");
  chk_oof_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_oof_release |=> (!oof_q && status_q[BIT_OOF]))
    else $error("oof clear not taken");
  chk_oof_thresh: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(oof_q) |-> ($past(err_cnt_q) + 3'h1 >= $past(thr_q)))
    else $error("oof declared before threshold");
  chk_no_sync_loss: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!oof_q && event_i.fas_err && thr_q > 3'h1 && err_cnt_q == 3'h0)
    |=> !oof_q)
    else $error("single framing error caused oof");
  chk_err_run: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!oof_q && fas_good_i && !event_i.fas_err) |=> (err_cnt_q == 3'h0))
    else $error("error run not ended by good pattern");

  // checks on the interrupt gate
  chk_irq_raise: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_irq_armed |=> irq_o)
    else $error("enabled flag raised no interrupt");
  chk_irq_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((status_q & enable_q) == 5'h0) |=> !irq_o)
    else $error("interrupt without enabled flag");

  // checks on the register bus answers
  chk_rd_answer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_arvalid_i && s_arready_o) |=> (s_rvalid_o && !s_arready_o))
    else $error("read not answered next cycle");
  chk_rd_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_rvalid_o && !s_rready_i) |=> (s_rvalid_o && $stable(s_rdata_o)))
    else $error("read data not held");
  chk_wr_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (s_bvalid_o && !s_bready_i) |=> s_bvalid_o)
    else $error("write response not held");

endmodule // fes_top
